// ==== src/crv_bus_decode.sv ====
`timescale 1ns/1ps
`include "crv_consts.svh"

module crv_bus_decode
  import crv_pkg::*;
(
  input  wire logic           wr_in,
  input  wire crv_pkg::crv_addr_t addr_in,
  input  wire crv_pkg::crv_data_t wdata_in,
  crv_ctrl_if.front           ctrl
);
  import crv_pkg::*;

  function automatic logic hit(input crv_addr_t a, input crv_addr_t idx);
    hit = (a == idx);
  endfunction : hit

  always_comb
  begin
    ctrl.soft_reset = wr_in && hit(addr_in, `CRV_IDX_RESET);
    ctrl.vol_we     = wr_in && hit(addr_in, `CRV_IDX_VOLUME);
    ctrl.mic_we     = wr_in && hit(addr_in, `CRV_IDX_MIC);
    ctrl.wdata      = wdata_in;
  end
endmodule : crv_bus_decode

// ==== src/crv_consts.svh ====
`ifndef CRV_CONSTS_SVH
`define CRV_CONSTS_SVH

`define CRV_ADDR_W        7
`define CRV_DATA_W        16
`define CRV_ATTEN_W       6

`define CRV_IDX_RESET     7'h00
`define CRV_IDX_VOLUME    7'h02
`define CRV_IDX_MIC       7'h0e

`define CRV_CAP_VALUE     16'h02a0
`define CRV_CAP_ADC_BIT   9
`define CRV_CAP_DAC_BIT   7
`define CRV_CAP_BASS_BIT  5

`define CRV_VOL_RESET     16'h8000
`define CRV_VOL_MUTE_BIT  15
`define CRV_VOL_LEFT_LSB  8
`define CRV_VOL_RIGHT_LSB 0
`define CRV_VOL_MASK      16'hbf3f

`define CRV_MIC_RESET     16'h0000
`define CRV_MIC_BOOST_BIT 6
`define CRV_MIC_MASK      16'h0040

`endif

// ==== src/crv_ctrl_if.sv ====
`timescale 1ns/1ps
// Decoded write events from the bus front end to the register store
interface crv_ctrl_if;
  logic                soft_reset;
  logic                vol_we;
  logic                mic_we;
  crv_pkg::crv_data_t  wdata;
  modport front (output soft_reset, output vol_we, output mic_we, output wdata);
  modport store (input soft_reset, input vol_we, input mic_we, input wdata);
endinterface : crv_ctrl_if

// ==== src/crv_pkg.sv ====
package crv_pkg;
  typedef logic [6:0]  crv_addr_t;
  typedef logic [15:0] crv_data_t;
  typedef logic [5:0]  crv_atten_t;
endpackage : crv_pkg

// ==== src/crv_regs.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "crv_consts.svh"

module crv_regs
  import crv_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               nrst_in,
  input  wire crv_pkg::crv_addr_t addr_in,
  input  wire crv_pkg::crv_data_t wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic [15:0]             rdata_out,
  output logic [5:0]              left_output_atten_out,
  output logic [5:0]              right_output_atten_out,
  output logic                    left_silent_out,
  output logic                    right_silent_out,
  output logic                    output_mute_out,
  output logic                    mic_boost_enable_out
);
  import crv_pkg::*;

  crv_ctrl_if ctrl ();

  crv_data_t output_volume;
  crv_data_t mic_gain_boost;
  crv_data_t rdata;
  crv_data_t next_output_volume;
  crv_data_t next_mic_gain_boost;
  crv_data_t next_rdata;

  // ==========================================
  // Write decode
  crv_bus_decode u_decode (
    .wr_in    (wr_in),
    .addr_in  (addr_in),
    .wdata_in (wdata_in),
    .ctrl     (ctrl)
  );

  function automatic crv_data_t read_mux(input crv_addr_t a, input crv_data_t vol,
                                         input crv_data_t mic);
    case (a)
      `CRV_IDX_RESET:  read_mux = `CRV_CAP_VALUE;
      `CRV_IDX_VOLUME: read_mux = vol & `CRV_VOL_MASK;
      `CRV_IDX_MIC:    read_mux = mic & `CRV_MIC_MASK;
      default:         read_mux = 16'h0000;
    endcase
  endfunction : read_mux

  // ==========================================
  // Register store
  always_comb
  begin
    next_output_volume  = output_volume;
    next_mic_gain_boost = mic_gain_boost;
    if (ctrl.soft_reset)
    begin
      next_output_volume  = `CRV_VOL_RESET;
      next_mic_gain_boost = `CRV_MIC_RESET;
    end
    else
    begin
      if (ctrl.vol_we)
        next_output_volume = ctrl.wdata & `CRV_VOL_MASK;
      if (ctrl.mic_we)
        next_mic_gain_boost = ctrl.wdata & `CRV_MIC_MASK;
    end
    next_rdata = rd_in ? read_mux(addr_in, output_volume, mic_gain_boost) : 16'h0000;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      output_volume  <= `CRV_VOL_RESET;
      mic_gain_boost <= `CRV_MIC_RESET;
      rdata          <= 16'h0000;
    end
    else
    begin
      output_volume  <= next_output_volume;
      mic_gain_boost <= next_mic_gain_boost;
      rdata          <= next_rdata;
    end
  end

  // ==========================================
  // Outputs
  always_comb
  begin
    rdata_out              = rdata;
    output_mute_out        = output_volume[`CRV_VOL_MUTE_BIT];
    left_output_atten_out  = output_volume[`CRV_VOL_LEFT_LSB +: 6];
    right_output_atten_out = output_volume[`CRV_VOL_RIGHT_LSB +: 6];
    left_silent_out        = output_volume[`CRV_VOL_MUTE_BIT];
    right_silent_out       = output_volume[`CRV_VOL_MUTE_BIT];
    mic_boost_enable_out   = mic_gain_boost[`CRV_MIC_BOOST_BIT];
  end

  // ==========================================
  // Checks
  // Only three indices decode, two of them to storage
  function automatic logic is_mapped(input crv_addr_t a);
    is_mapped = (a == `CRV_IDX_RESET) || (a == `CRV_IDX_VOLUME) || (a == `CRV_IDX_MIC);
  endfunction : is_mapped

  sequence rd_cap_s;
    rd_in && addr_in == `CRV_IDX_RESET;
  endsequence

  sequence rd_vol_s;
    rd_in && addr_in == `CRV_IDX_VOLUME;
  endsequence

  sequence rd_mic_s;
    rd_in && addr_in == `CRV_IDX_MIC;
  endsequence

  sequence rd_unmapped_s;
    rd_in && !is_mapped(addr_in);
  endsequence

  sequence wr_reset_s;
    wr_in && addr_in == `CRV_IDX_RESET;
  endsequence

  sequence wr_vol_s;
    wr_in && addr_in == `CRV_IDX_VOLUME;
  endsequence

  sequence wr_mic_s;
    wr_in && addr_in == `CRV_IDX_MIC;
  endsequence

  sequence wr_unmapped_s;
    wr_in && !is_mapped(addr_in);
  endsequence

  // Soft reset, then a capability read one or two cycles on
  sequence reset_then_cap_s;
    wr_reset_s ##[1:2] rd_cap_s;
  endsequence

  // Capability register
  cap_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_cap_s
    |=> rdata_out == `CRV_CAP_VALUE)
    else $error("capability read wrong");

  cap_bit9_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_cap_s
    |=> rdata_out[`CRV_CAP_ADC_BIT])
    else $error("adc capability bit low");

  cap_bit7_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_cap_s
    |=> rdata_out[`CRV_CAP_DAC_BIT])
    else $error("dac capability bit low");

  cap_bit5_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_cap_s
    |=> rdata_out[`CRV_CAP_BASS_BIT])
    else $error("bass capability bit low");

  cap_reserved_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_cap_s
    |=> (rdata_out & ~`CRV_CAP_VALUE) == 16'h0000)
    else $error("capability reserved bits nonzero");

  cap_after_reset_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    reset_then_cap_s
    |=> rdata_out == `CRV_CAP_VALUE)
    else $error("capability changed by write");

  // Soft reset
  soft_reset_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_reset_s
    |=> output_volume == `CRV_VOL_RESET && !mic_boost_enable_out)
    else $error("soft reset did not restore defaults");

  soft_reset_mic_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_reset_s
    |=> mic_gain_boost == `CRV_MIC_RESET)
    else $error("soft reset left mic register set");

  reset_outputs_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_reset_s
    |=> output_mute_out && left_output_atten_out == 6'h00 && right_output_atten_out == 6'h00)
    else $error("soft reset volume outputs wrong");

  reset_silent_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_reset_s
    |=> left_silent_out && right_silent_out)
    else $error("soft reset did not silence");

  // Stores
  mute_write_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vol_s
    |=> output_mute_out == $past(wdata_in[`CRV_VOL_MUTE_BIT]))
    else $error("mute bit not stored");

  left_atten_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vol_s
    |=> left_output_atten_out == $past(wdata_in[`CRV_VOL_LEFT_LSB +: `CRV_ATTEN_W]))
    else $error("left attenuation not stored");

  right_atten_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vol_s
    |=> right_output_atten_out == $past(wdata_in[`CRV_VOL_RIGHT_LSB +: `CRV_ATTEN_W]))
    else $error("right attenuation not stored");

  mic_boost_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_mic_s
    |=> mic_boost_enable_out == $past(wdata_in[`CRV_MIC_BOOST_BIT]))
    else $error("mic boost not stored");

  vol_store_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vol_s
    |=> (output_volume & ~`CRV_VOL_MASK) == 16'h0000)
    else $error("reserved volume bits stored");

  mic_store_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_mic_s
    |=> (mic_gain_boost & ~`CRV_MIC_MASK) == 16'h0000)
    else $error("reserved mic bits stored");

  // Read path
  reserved_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_vol_s
    |=> (rdata_out & ~`CRV_VOL_MASK) == 16'h0000)
    else $error("reserved volume bits nonzero");

  vol_readback_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_vol_s
    |=> rdata_out == {$past(output_mute_out), 1'b0, $past(left_output_atten_out),
                      2'b00, $past(right_output_atten_out)})
    else $error("volume read back wrong");

  mic_readback_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_mic_s
    |=> rdata_out == {9'h000, $past(mic_boost_enable_out), 6'h00})
    else $error("mic read back wrong");

  mic_reserved_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_mic_s
    |=> (rdata_out & ~`CRV_MIC_MASK) == 16'h0000)
    else $error("reserved mic bits nonzero");

  unmapped_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_unmapped_s
    |=> rdata_out == 16'h0000)
    else $error("unmapped index read nonzero");

  read_idle_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !rd_in
    |=> rdata_out == 16'h0000)
    else $error("read data outside read cycle");

  // Hold and silence
  unmapped_write_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_unmapped_s
    |=> $stable(output_volume) && $stable(mic_gain_boost))
    else $error("unmapped write changed a register");

  read_no_effect_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_in
    |=> $stable(output_volume) && $stable(mic_gain_boost))
    else $error("read changed a register");

  codes_kept_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !(wr_in && (addr_in == `CRV_IDX_RESET || addr_in == `CRV_IDX_VOLUME))
    |=> $stable(left_output_atten_out) && $stable(right_output_atten_out) && $stable(output_mute_out))
    else $error("volume fields changed without write");

  mic_kept_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !(wr_in && (addr_in == `CRV_IDX_RESET || addr_in == `CRV_IDX_MIC))
    |=> $stable(mic_boost_enable_out))
    else $error("mic boost changed without write");

  mute_silence_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    output_mute_out
    |-> left_silent_out && right_silent_out)
    else $error("mute does not silence");

  unmute_sound_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !output_mute_out
    |-> !left_silent_out && !right_silent_out)
    else $error("silence without mute");

endmodule : crv_regs

// ==== tb/crv_host.sv ====
`timescale 1ns/1ps
module crv_host
  import crv_pkg::*;
(
  input  wire logic      clk_in,
  input  wire crv_data_t rdata_in,
  output crv_addr_t      addr_out,
  output crv_data_t      wdata_out,
  output logic           wr_out,
  output logic           rd_out
);
  initial
  begin
    addr_out  = 7'h00;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // Index zero write is how the host resets registers
  task automatic wr(input crv_addr_t a, input crv_data_t d);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
    @(posedge clk_in);
  endtask : wr
  // Read data stand in the cycle after the strobe; taken at its closing edge
  task automatic rd(input crv_addr_t a, output crv_data_t d);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask : rd
endmodule : crv_host

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import crv_pkg::*;
  logic       sys_clk_in, nrst_in, wr, rd, ls, rs, mu, mb;
  crv_addr_t  addr;
  crv_data_t  wdata, rdata, d, v, m;
  logic [5:0] la, ra;
  int         failures, num_checks;
  crv_regs DUT (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .left_output_atten_out(la), .right_output_atten_out(ra), .left_silent_out(ls),
    .right_silent_out(rs), .output_mute_out(mu), .mic_boost_enable_out(mb));
  crv_host host (.clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  function automatic crv_data_t fvol(crv_data_t w);
    return w & 16'hbf3f;
  endfunction : fvol
  task automatic chk(string n, crv_data_t e, crv_data_t s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Outputs mirror the volume word; mute drives silence
  task automatic outs(crv_data_t e);
    @(negedge sys_clk_in);
    chk("outs", {e[15], 1'b0, e[13:8], 2'b00, e[5:0]}, {mu, 1'b0, la, 2'b00, ra});
    chk("silent", {2{e[15]}}, {ls, rs});
    @(posedge sys_clk_in);
  endtask : outs
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
  initial
  begin
    nrst_in = 1'b0;
    void'($urandom(32'hcc69));
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    host.rd(7'h00, d);
    chk("cap", 16'h02a0, d);
    host.rd(7'h02, d);
    chk("vol", 16'h8000, d);
    outs(16'h8000);
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h3f00 : crv_data_t'($urandom);
      m = crv_data_t'($urandom);
      host.wr(7'h02, v);
      host.wr(7'h0e, m);
      host.rd(7'h02, d);
      chk("vol", fvol(v), d);
      host.rd(7'h0e, d);
      chk("mic", m & 16'h0040, d);
      chk("boost", {15'h0000, m[6]}, {15'h0000, mb});
      outs(fvol(v));
      host.wr(7'h04, ~v);
      host.rd(7'h04, d);
      chk("unmapped", 16'h0000, d);
      host.rd(7'h02, d);
      chk("vol_kept", fvol(v), d);
    end
    host.wr(7'h02, 16'h3f3f);
    host.wr(7'h0e, 16'h0040);
    host.wr(7'h00, 16'hffff);
    host.rd(7'h00, d);
    chk("cap", 16'h02a0, d);
    chk("adc_cap", 16'h0001, {15'h0000, d[9]});
    chk("dac_cap", 16'h0001, {15'h0000, d[7]});
    chk("bass_cap", 16'h0001, {15'h0000, d[5]});
    host.rd(7'h02, d);
    chk("vol", 16'h8000, d);
    host.rd(7'h0e, d);
    chk("mic", 16'h0000, d);
    outs(16'h8000);
    // Hardware reset in mid-run restores defaults too
    host.wr(7'h02, 16'h1234);
    host.wr(7'h0e, 16'h0040);
    nrst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    host.rd(7'h02, d);
    chk("vol_rst", 16'h8000, d);
    host.rd(7'h0e, d);
    chk("mic_rst", 16'h0000, d);
    outs(16'h8000);
    end_sim();
  end
endmodule : tb
